// ### rtl/osc_ctrl_consts.svh
/*
  offsets, field positions, reset values and timing counts for the
  oscillator control and status block; include where needed.
*/
`ifndef OSC_CTRL_CONSTS_SVH
`define OSC_CTRL_CONSTS_SVH

`define OSC_CTRL_OFFSET 4'h0
`define OSC_STAT_OFFSET 4'h1
`define OSC_CTRL_RESET 8'h38
`define OSC_FREQ_DEFAULT 4'h7
`define OSC_CTRL_MULT_BIT 7
`define OSC_CTRL_FREQ_HI 6
`define OSC_CTRL_FREQ_LO 3
`define OSC_CTRL_SRC_HI 1
`define OSC_CTRL_SRC_LO 0
`define OSC_STARTUP_COUNT 1024
`define OSC_CFG_INTOSC_MODE 3'h4

`endif

// ### rtl/osc_ctrl_pkg.sv
/*
  types for the oscillator control block; no assumptions.
*/
package osc_ctrl_pkg;
  typedef enum logic [1:0] {
    SRC_CONFIG = 2'b00,
    SRC_TIMER1 = 2'b01,
    SRC_INTERNAL = 2'b11
  } clk_src_e;

  typedef enum logic [1:0] {
    OSC_LOW = 2'b00,
    OSC_MID = 2'b01,
    OSC_HIGH = 2'b11
  } int_osc_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COUNT = 2'b01,
    ST_DONE = 2'b11
  } startup_e;
endpackage

// ### rtl/freq_decode.sv
/*
  maps the internal frequency select code to oscillator and divider;
  assumes a registered code on the same clock.
*/
`timescale 1ns/1ps
module freq_decode
  import osc_ctrl_pkg::*;
(
  input wire logic [3:0] internal_freq_select,
  output osc_ctrl_pkg::int_osc_e osc_sel,
  output logic [9:0] div_log
);
  // duplicates come from the high oscillator by division
  always_comb begin
    osc_sel = OSC_HIGH;
    div_log = 10'h000;
    case (internal_freq_select)
      4'h0, 4'h1: begin
        osc_sel = OSC_LOW;
        div_log = 10'h000;
      end
      4'h2: begin
        osc_sel = OSC_MID;
        div_log = 10'h004;
      end
      4'h3: div_log = 10'h009;
      4'h4: begin
        osc_sel = OSC_MID;
        div_log = 10'h003;
      end
      4'h5: begin
        osc_sel = OSC_MID;
        div_log = 10'h002;
      end
      4'h6: begin
        osc_sel = OSC_MID;
        div_log = 10'h001;
      end
      4'h7: begin
        osc_sel = OSC_MID;
        div_log = 10'h000;
      end
      4'h8: div_log = 10'h007;
      4'h9: div_log = 10'h006;
      4'ha: div_log = 10'h005;
      4'hb: div_log = 10'h004;
      4'hc: div_log = 10'h003;
      4'hd: div_log = 10'h002;
      4'he: div_log = 10'h001;
      default: div_log = 10'h000;
    endcase
  end
endmodule

// ### rtl/startup_timer.sv
/*
  counts external oscillator pulses before switchover; the pulse
  input is already synchronised to core_clk.
*/
`timescale 1ns/1ps
`include "osc_ctrl_consts.svh"
module startup_timer
  import osc_ctrl_pkg::*;
#(
  parameter int COUNT = `OSC_STARTUP_COUNT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic restart,
  input wire logic enable,
  input wire logic osc_tick,
  output logic done
);
  typedef struct packed {
    startup_e st;
    logic [10:0] cnt;
  } tmr_s;
  tmr_s q, d;

  // restart beats everything so a source change always re-times
  always_comb begin
    d = q;
    if (restart || !enable) begin
      d.st = ST_COUNT;
      d.cnt = 11'h000;
    end else if (q.st == ST_COUNT && osc_tick) begin
      if (q.cnt == 11'(COUNT - 1))
        d.st = ST_DONE;
      else
        d.cnt = q.cnt + 11'h001;
    end
  end

  // counting from reset, so the first start-up is timed without a write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: ST_COUNT, cnt: 11'h000};
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign done = (q.st == ST_DONE);
endmodule

// ### rtl/oscillator_control_status_regs.sv
/*
  oscillator control and status registers with start-up timing and
  clock source choice; assumes oscillator status pins come from other
  domains and are synchronised here, plain register port on core_clk.
*/
// Behaviour
// - frequency code maps to fixed oscillator frequency
// - duplicate codes divide the high oscillator
// - source select picks internal, timer1, config
// - timer1 ready follows oscillator when enabled
// - timer1 ready reads one when disabled
// - timeout status set when running config clock
// - high oscillator ready bit reflects readiness
// - high oscillator locked within two percent
// - mid oscillator ready bit reflects readiness
// - low oscillator ready bit reflects readiness
// - high oscillator stable within half percent
// - crystal modes wait 1024 oscillations first
// - failsafe fallback uses selected internal clock
// - changing source select restarts start-up timer
`timescale 1ns/1ps
`include "osc_ctrl_consts.svh"
module oscillator_control_status_regs
  import osc_ctrl_pkg::*;
#(
  parameter int STARTUP_COUNT = `OSC_STARTUP_COUNT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] cfg_osc_mode,
  input wire logic cfg_mult_enable,
  input wire logic timer1_osc_enable,
  input wire logic timer1_osc_rdy_in,
  input wire logic mult_rdy_in,
  input wire logic ext_osc_tick,
  input wire logic ext_osc_failed,
  input wire logic high_osc_rdy_in,
  input wire logic high_osc_lock_in,
  input wire logic mid_osc_rdy_in,
  input wire logic low_osc_rdy_in,
  input wire logic high_osc_stable_in,
  output logic mult_enable,
  output logic [1:0] sysclk_sel,
  output logic [1:0] int_osc_sel,
  output logic [9:0] int_div_log
);
  localparam int NSYNC = 9;

  typedef struct packed {
    logic soft_mult_enable;
    logic [3:0] internal_freq_select;
    logic [1:0] sysclk_source_select;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic tick_prev;
    logic [7:0] rdata;
    logic [1:0] sysclk;
  } regs_s;
  regs_s q, d;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s;
  logic timer1_osc_ready, mult_ready, startup_timeout_status;
  logic high_int_osc_ready, high_int_osc_locked, mid_int_osc_ready;
  logic low_int_osc_ready, high_int_osc_stable;
  logic src_write, tick_pulse, crystal_mode, st_done, t1_en;
  logic [7:0] ctrl_word, stat_word;
  int_osc_e osc_sel;

  // asynchronous status pins gathered for one synchroniser bank
  assign raw_in = {timer1_osc_enable, timer1_osc_rdy_in, mult_rdy_in,
                   ext_osc_tick, high_osc_rdy_in, high_osc_lock_in,
                   mid_osc_rdy_in, low_osc_rdy_in, high_osc_stable_in};
  assign s = q.sync2;
  assign t1_en = s[8];

  // status bits read only second-stage values
  assign timer1_osc_ready = t1_en ? s[7] : 1'b1;
  assign mult_ready = s[6];
  assign high_int_osc_ready = s[4];
  assign high_int_osc_locked = s[3];
  assign mid_int_osc_ready = s[2];
  assign low_int_osc_ready = s[1];
  assign high_int_osc_stable = s[0];

  // rising edge of the external oscillator, seen after sync
  assign tick_pulse = s[5] & ~q.tick_prev;

  // only a change to the select field counts, same-value writes do not
  assign src_write = reg_wr && (reg_addr == `OSC_CTRL_OFFSET) &&
    (reg_wdata[`OSC_CTRL_SRC_HI:`OSC_CTRL_SRC_LO] !=
     q.sysclk_source_select);

  // crystal type config modes need the start-up count
  assign crystal_mode = (cfg_osc_mode < 3'h3);

  startup_timer #(
    .COUNT(STARTUP_COUNT)
  ) u_startup (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .restart(src_write),
    .enable(crystal_mode),
    .osc_tick(tick_pulse),
    .done(st_done)
  );

  freq_decode u_freq (
    .internal_freq_select(q.internal_freq_select),
    .osc_sel(osc_sel),
    .div_log(int_div_log)
  );

  assign int_osc_sel = osc_sel;

  // non-crystal modes need no wait; internal mode code never reports
  assign startup_timeout_status = (q.sysclk == SRC_CONFIG) &&
    (cfg_osc_mode != `OSC_CFG_INTOSC_MODE);

  // software or config bit turns the multiplier on
  assign mult_enable = q.soft_mult_enable | cfg_mult_enable;

  assign ctrl_word = {q.soft_mult_enable, q.internal_freq_select,
                      1'b0, q.sysclk_source_select};
  assign stat_word = {timer1_osc_ready, mult_ready,
                      startup_timeout_status, high_int_osc_ready,
                      high_int_osc_locked, mid_int_osc_ready,
                      low_int_osc_ready, high_int_osc_stable};

  // next-state: writes, source choice, synchronisers, read data
  always_comb begin
    d = q;
    d.sync1 = raw_in;
    d.sync2 = q.sync1;
    d.tick_prev = s[5];
    if (reg_wr && reg_addr == `OSC_CTRL_OFFSET) begin
      d.soft_mult_enable = reg_wdata[`OSC_CTRL_MULT_BIT];
      d.internal_freq_select =
        reg_wdata[`OSC_CTRL_FREQ_HI:`OSC_CTRL_FREQ_LO];
      d.sysclk_source_select =
        reg_wdata[`OSC_CTRL_SRC_HI:`OSC_CTRL_SRC_LO];
    end
    // source choice; internal fallback while waiting or failed
    if (q.sysclk_source_select[1])
      d.sysclk = SRC_INTERNAL;
    else if (q.sysclk_source_select == 2'b01)
      d.sysclk = SRC_TIMER1;
    else if (crystal_mode && !st_done)
      d.sysclk = SRC_INTERNAL;
    else if (ext_osc_failed)
      d.sysclk = SRC_INTERNAL;
    else if (cfg_osc_mode == `OSC_CFG_INTOSC_MODE)
      d.sysclk = SRC_INTERNAL;
    else
      d.sysclk = SRC_CONFIG;
    // read data stand one cycle after the strobe; unmapped read zero
    d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `OSC_CTRL_OFFSET: d.rdata = ctrl_word;
        `OSC_STAT_OFFSET: d.rdata = stat_word;
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // all state frozen while clock enable is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.soft_mult_enable <= 1'b0;
      q.internal_freq_select <= `OSC_FREQ_DEFAULT;
      q.sysclk_source_select <= 2'b00;
      q.sync1 <= '0;
      q.sync2 <= '0;
      q.tick_prev <= 1'b0;
      q.rdata <= 8'h00;
      q.sysclk <= 2'b11;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign sysclk_sel = q.sysclk;
endmodule

// ### sim/osc_regs_monitor.sv
/*
  port assertions for the oscillator control and status block.
  assumes one clock domain; the bind stands at the foot of this file.
*/
`timescale 1ns/1ps
module osc_regs_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cfg_mult_enable,
  input wire logic timer1_osc_enable,
  input wire logic ext_osc_failed,
  input wire logic mult_enable,
  input wire logic [1:0] sysclk_sel,
  input wire logic [1:0] int_osc_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] ctl_q;
  logic [2:0] age_q;
  // shadow of control; age lets the pin syncs fill after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= 8'h38;
      age_q <= 3'h0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == 4'h0)
        ctl_q <= reg_wdata & 8'hfb;
      if (age_q != 3'h7)
        age_q <= age_q + 3'h1;
    end
  end
  function automatic logic [1:0] osc_of(input logic [3:0] c);
    if (c[3:1] == 3'h0)
      return 2'h0;
    if (c[3] || c == 4'h3)
      return 2'h3;
    return 2'h1;
  endfunction
  mult_on_a: assert property (
    mult_enable == (ctl_q[7] | cfg_mult_enable)) else $error("mult enable");
  osc_pick_a: assert property (
    int_osc_sel == osc_of(ctl_q[6:3])) else $error("osc select");
  ctl_read_a: assert property (
    clk_en && reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(ctl_q))
    else $error("control read");
  src_int_a: assert property (
    clk_en && ctl_q[1] |=> sysclk_sel == 2'h3) else $error("internal src");
  src_t1_a: assert property (
    clk_en && ctl_q[1:0] == 2'h1 |=> sysclk_sel == 2'h1)
    else $error("timer1 src");
  fail_int_a: assert property (
    clk_en && ctl_q[1:0] == 2'h0 && ext_osc_failed
    |-> ##[1:2] sysclk_sel == 2'h3) else $error("no fallback");
  t1_idle_a: assert property (
    age_q == 3'h7 && clk_en && reg_rd && reg_addr == 4'h1 &&
    !timer1_osc_enable && !$past(timer1_osc_enable) &&
    !$past(timer1_osc_enable, 2) && !$past(timer1_osc_enable, 3)
    |=> reg_rdata[7]) else $error("timer1 ready clear");
  tmo_clear_a: assert property (
    clk_en && reg_rd && reg_addr == 4'h1 && sysclk_sel == 2'h3 &&
    $past(sysclk_sel) == 2'h3 |=> !reg_rdata[5]) else $error("timeout set");
endmodule

bind oscillator_control_status_regs osc_regs_monitor u_osc_regs_monitor (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cfg_mult_enable(cfg_mult_enable), .timer1_osc_enable(timer1_osc_enable),
  .ext_osc_failed(ext_osc_failed), .mult_enable(mult_enable),
  .sysclk_sel(sysclk_sel), .int_osc_sel(int_osc_sel)
);

// ### sim/test_oscillator_control_status_regs.sv
/*
  self-checking bench for the oscillator control and status block.
  assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/1ps
module test_oscillator_control_status_regs;
  logic core_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1;
  logic reg_wr = 1'h0, reg_rd = 1'h0, cfg_mult = 1'h0;
  logic tick = 1'h0, failed = 1'h0, mult_en;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d, v;
  logic [8:0] pins = 9'h000, p;
  logic [2:0] mode = 3'h0;
  logic [1:0] sel, osc;
  logic [9:0] div;
  logic [12:0] snap;
  int bad_count = 0, compares = 0;
  always #2 core_clk = ~core_clk;
  // pins: 8 timer1 enable, 7..6 and 4..0 status sources, 5 spare
  oscillator_control_status_regs #(.STARTUP_COUNT(4))
    u_oscillator_control_status_regs (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_osc_mode(mode),
    .cfg_mult_enable(cfg_mult), .timer1_osc_enable(pins[8]),
    .timer1_osc_rdy_in(pins[7]), .mult_rdy_in(pins[6]),
    .ext_osc_tick(tick), .ext_osc_failed(failed),
    .high_osc_rdy_in(pins[4]), .high_osc_lock_in(pins[3]),
    .mid_osc_rdy_in(pins[2]), .low_osc_rdy_in(pins[1]),
    .high_osc_stable_in(pins[0]), .mult_enable(mult_en),
    .sysclk_sel(sel), .int_osc_sel(osc), .int_div_log(div));
  function automatic logic [1:0] osc_of(input logic [3:0] c);
    if (c[3:1] == 3'h0)
      return 2'h0;
    if (c[3] || c == 4'h3)
      return 2'h3;
    return 2'h1;
  endfunction
  // a disabled timer1 always reports ready
  function automatic logic [7:0] stat_of(input logic [8:0] q);
    return {q[8] ? q[7] : 1'h1, q[6], 1'h0, q[4:0]};
  endfunction
  // log2 of oscillator over chosen frequency, both in quarter kHz
  function automatic logic [7:0] div_of(input logic [3:0] c);
    int f;
    int b;
    int n;
    n = 0;
    case (c)
      4'h0, 4'h1: f = 32'h0000_007c;
      4'h2, 4'h3: f = 32'h0000_007d;
      4'h4: f = 32'h0000_00fa;
      4'h5, 4'h8: f = 32'h0000_01f4;
      4'h6, 4'h9: f = 32'h0000_03e8;
      4'h7, 4'ha: f = 32'h0000_07d0;
      default: f = 32'h0000_0fa0 << (c - 4'hb);
    endcase
    if (osc_of(c) == 2'h3)
      b = 32'h0000_fa00;
    else if (osc_of(c) == 2'h1)
      b = 32'h0000_07d0;
    else
      b = 32'h0000_007c;
    while ((f << n) < b)
      n++;
    return 8'(n);
  endfunction
  // compares half a cycle after the edge, once outputs have settled
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    @(negedge core_clk);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
    @(posedge core_clk);
  endtask
  // select taken at a falling edge, never in the edge that launches it
  task automatic chk_sel(input logic [1:0] exp);
    @(negedge core_clk);
    chk({6'h0, sel}, {6'h0, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] dat);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    @(negedge core_clk);
    dat = reg_rdata;
    @(posedge core_clk);
  endtask
  // slow enough for the two-flop sync to see every edge
  task automatic ticks(input int n);
    repeat (n) begin
      tick <= 1'h1;
      repeat (2) @(posedge core_clk);
      tick <= 1'h0;
      repeat (2) @(posedge core_clk);
    end
  endtask
  task automatic close_out();
    $display("counts: %0d compares, %0d wrong", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog well beyond the roughly 1400 ns the tests take
  initial begin
    #40000;
    bad_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'hee64));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    rd(4'h0, d);
    chk(d, 8'h38);
    chk_sel(2'h3);
    for (int c = 0; c < 16; c++) begin
      v = {1'($urandom), c[3:0], 3'($urandom)};
      if (c == 1)
        v[1:0] = 2'h1;
      cfg_mult <= 1'($urandom);
      wr(4'h0, v);
      rd(4'h0, d);
      chk(d, v & 8'hfb);
      // one snapshot at the falling edge, away from the launch edge
      @(negedge core_clk);
      snap = {mult_en, osc, div};
      chk({6'h0, snap[11:10]}, {6'h0, osc_of(v[6:3])});
      chk({7'h0, snap[12]}, {7'h0, v[7] | cfg_mult});
      chk(snap[7:0], div_of(v[6:3]));
      chk({6'h0, snap[9:8]}, 8'h00);
      if (v[1])
        chk_sel(2'h3);
      if (v[1:0] == 2'h1)
        chk_sel(2'h1);
    end
    // status ignores writes, unmapped reads zero, frozen clock ignores
    wr(4'h1, 8'hff);
    rd(4'h5, d);
    chk(d, 8'h00);
    clk_en <= 1'h0;
    wr(4'h0, 8'h3a);
    clk_en <= 1'h1;
    rd(4'h0, d);
    chk(d, v & 8'hfb);
    $display("control test done");
    wr(4'h0, 8'h3b);
    for (int i = 0; i < 14; i++) begin
      p = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : 9'($urandom);
      pins <= p;
      repeat (3) @(posedge core_clk);
      rd(4'h1, d);
      chk(d, stat_of(p));
    end
    $display("status test done");
    wr(4'h0, 8'h38);
    ticks(3);
    chk_sel(2'h3);
    ticks(1);
    repeat (4) @(posedge core_clk);
    chk_sel(2'h0);
    rd(4'h1, d);
    chk({7'h0, d[5]}, 8'h01);
    failed <= 1'h1;
    repeat (3) @(posedge core_clk);
    chk_sel(2'h3);
    failed <= 1'h0;
    wr(4'h0, 8'h3b);
    // an edge between the writes keeps one strobe change per step
    @(posedge core_clk);
    wr(4'h0, 8'h38);
    ticks(3);
    chk_sel(2'h3);
    ticks(1);
    repeat (4) @(posedge core_clk);
    chk_sel(2'h0);
    mode <= 3'h4;
    repeat (3) @(posedge core_clk);
    rd(4'h1, d);
    chk({7'h0, d[5]}, 8'h00);
    // a non-crystal external mode switches over with no count
    mode <= 3'h3;
    repeat (3) @(posedge core_clk);
    chk_sel(2'h0);
    rd(4'h1, d);
    chk({7'h0, d[5]}, 8'h01);
    $display("start-up test done");
    close_out();
  end
endmodule
